// ==== design/tsc_timing_control.sv ====
// Function
// - PLL enable bit ignored in master mode
// - Slave PLL on only with bit and crystal
// - Enabled PLL: low outputs input-timed, high reference-locked
// - Two-bit field selects master or slave
// - Loopback low: pins used; ignored in slave
// - Loopback high: output clock/frame 2 substituted
// - Position low: frame pulse straddles boundary
// - Position high: frame pulse begins boundary
`default_nettype none
module tsc_timing_control #(
    parameter int SYNC_STAGES = tsc_pkg::SYNC_STAGES_DEF
) (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    // Host register port
    input  wire logic        host_wr_en,
    input  wire logic        host_rd_en,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata_q,
    // Crystal source enable from the oscillator control
    input  wire logic        crystal_source_enable,
    // External input timing pins
    input  wire logic        input_clock_pin,
    input  wire logic        input_frame_pulse,
    // Device-generated output clock 2 and frame pulse 2
    input  wire logic        output_clock2,
    input  wire logic        output_frame_pulse2,
    // Status and steering
    output logic             slave_mode_q,
    output logic             pll_enable_q,
    output logic             loopback_q,
    output logic [3:0]       low_group_from_input_q,
    output logic [1:0]       high_group_from_ref_q,
    output logic             timing_clk_q,
    output logic             timing_fp_q,
    output logic             frame_boundary_q
);
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [1:0]  pin_sync;
    logic        fp_begin_mode_q;
    logic        tclk_prev_q;
    logic [1:0]  fp_hist_q;
    logic        tclk_rise;
    logic        boundary_d;

    initial begin
        if (SYNC_STAGES < 2) begin
            $error("tsc_timing_control: SYNC_STAGES must be at least 2");
        end
    end

    // Timing pins come from another domain
    tsc_sync #(
        .WIDTH  (2),
        .STAGES (SYNC_STAGES)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .clk_en   (clk_en),
        .async_in ({input_clock_pin, input_frame_pulse}),
        .sync_out (pin_sync)
    );

    // Control register; unused top bits stay zero
    always_comb begin
        ctrl_d = ctrl_q;
        if (host_wr_en) begin
            ctrl_d = host_wdata & tsc_pkg::CTRL_WRITE_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= tsc_pkg::CTRL_RESET;
        end else if (clk_en) begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            host_rdata_q <= '0;
        end else if (clk_en && host_rd_en) begin
            host_rdata_q <= ctrl_q;
        end
    end

    // Mode decode and PLL gating
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            slave_mode_q           <= 1'b0;
            pll_enable_q           <= 1'b0;
            loopback_q             <= 1'b0;
            low_group_from_input_q <= '0;
            high_group_from_ref_q  <= '0;
            fp_begin_mode_q        <= 1'b0;
        end else if (clk_en) begin
            slave_mode_q <= ctrl_q[tsc_pkg::BIT_OPSEL_HI:tsc_pkg::BIT_OPSEL_LO]
                            != tsc_pkg::OPSEL_MASTER;
            pll_enable_q <= (ctrl_q[tsc_pkg::BIT_OPSEL_HI:tsc_pkg::BIT_OPSEL_LO] != tsc_pkg::OPSEL_MASTER)
                            && ctrl_q[tsc_pkg::BIT_PLL_EN] && crystal_source_enable;
            loopback_q   <= (ctrl_q[tsc_pkg::BIT_OPSEL_HI:tsc_pkg::BIT_OPSEL_LO] == tsc_pkg::OPSEL_MASTER)
                            && ctrl_q[tsc_pkg::BIT_LOOPBACK];
            low_group_from_input_q <= {tsc_pkg::LOW_GROUP_CLKS{pll_enable_q}};
            high_group_from_ref_q  <= {tsc_pkg::HIGH_GROUP_CLKS{pll_enable_q}};
            fp_begin_mode_q <= ctrl_q[tsc_pkg::BIT_FP_POSITION];
        end
    end

    // Input timing source: pins or looped-back output clock/frame 2
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            timing_clk_q <= 1'b0;
            timing_fp_q  <= 1'b0;
        end else if (clk_en) begin
            timing_clk_q <= loopback_q ? output_clock2 : pin_sync[1];
            timing_fp_q  <= loopback_q ? output_frame_pulse2 : pin_sync[0];
        end
    end

    // Frame boundary from sampled frame pulse on input clock rising edges
    assign tclk_rise = timing_clk_q && !tclk_prev_q;

    always_comb begin
        if (fp_begin_mode_q) begin
            boundary_d = tclk_rise && timing_fp_q && !fp_hist_q[0];
        end else begin
            boundary_d = tclk_rise && fp_hist_q[0] && !fp_hist_q[1];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tclk_prev_q      <= 1'b0;
            fp_hist_q        <= '0;
            frame_boundary_q <= 1'b0;
        end else if (clk_en) begin
            tclk_prev_q      <= timing_clk_q;
            frame_boundary_q <= boundary_d;
            if (tclk_rise) begin
                fp_hist_q <= {fp_hist_q[0], timing_fp_q};
            end
        end
    end

    // Checks
    // Request decoded from the live register, not the registered mode flag, which lags one cycle
    sequence s_pll_request;
        clk_en && (ctrl_q[tsc_pkg::BIT_OPSEL_HI:tsc_pkg::BIT_OPSEL_LO] != tsc_pkg::OPSEL_MASTER)
        && ctrl_q[tsc_pkg::BIT_PLL_EN] && crystal_source_enable;
    endsequence

    sequence s_pll_request_held;
        s_pll_request ##1 clk_en;
    endsequence

    property p_master_no_pll;
        @(posedge sys_clk) disable iff (!nrst)
        !slave_mode_q |-> !pll_enable_q;
    endproperty
    a_master_no_pll: assert property (p_master_no_pll) else $error("PLL enabled in master mode");

    property p_pll_needs_bit;
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && !ctrl_q[tsc_pkg::BIT_PLL_EN] |=> !pll_enable_q;
    endproperty
    a_pll_needs_bit: assert property (p_pll_needs_bit) else $error("PLL enabled with bit low");

    property p_pll_on;
        @(posedge sys_clk) disable iff (!nrst)
        s_pll_request_held |-> pll_enable_q;
    endproperty
    a_pll_on: assert property (p_pll_on) else $error("PLL not enabled when requested");

    property p_groups_follow;
        @(posedge sys_clk) disable iff (!nrst)
        clk_en |=> (low_group_from_input_q == {tsc_pkg::LOW_GROUP_CLKS{$past(pll_enable_q)}})
                   && (high_group_from_ref_q == {tsc_pkg::HIGH_GROUP_CLKS{$past(pll_enable_q)}});
    endproperty
    a_groups_follow: assert property (p_groups_follow) else $error("Output group steering wrong");

    property p_mode_decode;
        @(posedge sys_clk) disable iff (!nrst)
        clk_en |=> slave_mode_q
                   == ($past(ctrl_q[tsc_pkg::BIT_OPSEL_HI:tsc_pkg::BIT_OPSEL_LO]) != tsc_pkg::OPSEL_MASTER);
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("Mode decode wrong");

    property p_loop_slave_off;
        @(posedge sys_clk) disable iff (!nrst)
        slave_mode_q |-> !loopback_q;
    endproperty
    a_loop_slave_off: assert property (p_loop_slave_off) else $error("Loopback active in slave mode");

    property p_loop_source;
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && loopback_q |=> timing_clk_q == $past(output_clock2) && timing_fp_q == $past(output_frame_pulse2);
    endproperty
    a_loop_source: assert property (p_loop_source) else $error("Loopback source wrong");

    property p_pin_source;
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && !loopback_q |=> timing_clk_q == $past(pin_sync[1]) && timing_fp_q == $past(pin_sync[0]);
    endproperty
    a_pin_source: assert property (p_pin_source) else $error("Pin source wrong");

    property p_begin_boundary;
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && fp_begin_mode_q && tclk_rise && timing_fp_q && !fp_hist_q[0] |=> frame_boundary_q;
    endproperty
    a_begin_boundary: assert property (p_begin_boundary) else $error("Begin boundary missed");

    property p_straddle_boundary;
        @(posedge sys_clk) disable iff (!nrst)
        clk_en && !fp_begin_mode_q && tclk_rise |=> frame_boundary_q == ($past(fp_hist_q[0]) && !$past(fp_hist_q[1]));
    endproperty
    a_straddle_boundary: assert property (p_straddle_boundary) else $error("Straddle boundary wrong");
endmodule : tsc_timing_control
`default_nettype wire

// ==== design/tsc_pkg.sv ====
`default_nettype none
package tsc_pkg;
    localparam int          CTRL_W           = 16;
    localparam logic [15:0] CTRL_RESET       = 16'h0000;
    localparam logic [15:0] CTRL_WRITE_MASK  = 16'h3fff;
    localparam int          BIT_PLL_EN       = 13;
    localparam int          BIT_OPSEL_HI     = 12;
    localparam int          BIT_OPSEL_LO     = 11;
    localparam int          BIT_LOOPBACK     = 10;
    localparam int          BIT_FP_POSITION  = 9;
    localparam logic [1:0]  OPSEL_MASTER     = 2'h0;
    localparam int          SYNC_STAGES_DEF  = 2;
    localparam int          LOW_GROUP_CLKS   = 4;
    localparam int          HIGH_GROUP_CLKS  = 2;
endpackage : tsc_pkg
`default_nettype wire

// ==== design/tsc_sync.sv ====
`default_nettype none
module tsc_sync #(
    parameter int WIDTH  = 1,
    parameter int STAGES = 2
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             clk_en,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_q [STAGES];

    initial begin
        if (STAGES < 2 || WIDTH < 1) begin
            $error("tsc_sync: STAGES must be at least 2 and WIDTH at least 1");
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_q[i] <= '0;
            end
        end else if (clk_en) begin
            stage_q[0] <= async_in;
            for (int i = 1; i < STAGES; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign sync_out = stage_q[STAGES-1];
endmodule : tsc_sync
`default_nettype wire

// ==== bench/tsc_backplane.sv ====
`default_nettype none
module tsc_backplane #(
    parameter int HALF  = 3,
    parameter int FRAME = 8
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Pins stand idle low while run is low
    input  wire logic run,
    // Timing pins
    output logic      clk_pin,
    output logic      fp_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int ph;
    int bitn;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ph   <= 0;
            bitn <= 0;
        end else begin
            ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
            if (ph == 2 * HALF - 1) begin
                bitn <= (bitn == FRAME - 1) ? 0 : bitn + 1;
            end
        end
    end
    // Frame pulse spans one clock period around the rise of bit 0
    assign clk_pin = run && (ph < HALF);
    assign fp_pin  = run && ((bitn == FRAME - 1 && ph >= HALF) || (bitn == 0 && ph < HALF));
endmodule : tsc_backplane
`default_nettype wire

// ==== bench/test_tsc_timing_control.sv ====
`default_nettype none
module test_tsc_timing_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, nrst, clk_en, host_wr_en, host_rd_en, crystal_source_enable;
    logic        slave_mode_q, pll_enable_q, loopback_q, timing_clk_q, timing_fp_q;
    logic        frame_boundary_q, ck_pin, fp_pin, run, ck2, fp2;
    logic [15:0] host_wdata, host_rdata_q, d, r;
    logic [3:0]  low_group_from_input_q;
    logic [1:0]  high_group_from_ref_q;
    logic [2:0]  e;
    int          num_errors, n_checks, seed, cyc, dly[2];

    tsc_timing_control dut (.sys_clk, .nrst, .clk_en, .host_wr_en, .host_rd_en, .host_wdata,
        .host_rdata_q, .crystal_source_enable, .input_clock_pin(ck_pin), .input_frame_pulse(fp_pin),
        .output_clock2(ck2), .output_frame_pulse2(fp2), .slave_mode_q, .pll_enable_q, .loopback_q,
        .low_group_from_input_q, .high_group_from_ref_q, .timing_clk_q, .timing_fp_q, .frame_boundary_q);
    tsc_backplane bp (.sys_clk, .nrst, .run, .clk_pin(ck_pin), .fp_pin);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    function automatic logic [2:0] exp_mode(input logic [4:0] k);
        logic sl;
        sl = k[2:1] != 2'h0;
        return {sl, sl & k[3] & k[4], !sl & k[0]};
    endfunction : exp_mode

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task end_of_test;
        $display("Checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task wr(input logic [15:0] v);
        @(posedge sys_clk);
        host_wr_en <= 1'b1;
        host_wdata <= v;
        @(posedge sys_clk);
        host_wr_en <= 1'b0;
    endtask : wr

    task rd(output logic [15:0] v);
        @(posedge sys_clk);
        host_rd_en <= 1'b1;
        @(posedge sys_clk);
        host_rd_en <= 1'b0;
        @(negedge sys_clk);
        v = host_rdata_q;
    endtask : rd

    // Delay from pin frame pulse rise to detected boundary
    task meas(input int i);
        int t;
        wr(16'h0200 * 16'(i));
        repeat (100) @(negedge sys_clk);
        while (fp_pin) @(negedge sys_clk);
        while (!fp_pin) @(negedge sys_clk);
        t = cyc;
        while (!frame_boundary_q && cyc - t < 60) @(negedge sys_clk);
        dly[i] = cyc - t;
    endtask : meas

    initial begin
        repeat (6000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        seed = 95;
        nrst = 1'b0;
        clk_en = 1'b1;
        host_wr_en = 1'b0;
        host_rd_en = 1'b0;
        host_wdata = 16'h0000;
        crystal_source_enable = 1'b0;
        run = 1'b1;
        ck2 = 1'b0;
        fp2 = 1'b0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(r);
        chk("reset value", r, 16'h0000);
        chk("reset outputs", {slave_mode_q, pll_enable_q, loopback_q, low_group_from_input_q}, 16'h0000);
        $display("Test reset done");
        for (int k = 0; k < 32; k++) begin
            d = 16'($random(seed));
            d[13:10] = 4'(k);
            @(posedge sys_clk);
            crystal_source_enable <= k[4];
            wr(d);
            repeat (3) @(posedge sys_clk);
            rd(r);
            e = exp_mode(5'(k));
            chk("readback", r, d & 16'h3fff);
            chk("mode", {slave_mode_q, pll_enable_q, loopback_q}, e);
            chk("groups", {low_group_from_input_q, high_group_from_ref_q}, {6{e[1]}});
        end
        $display("Test mode table done");
        meas(0);
        meas(1);
        chk("frame offset", 16'(dly[0] - dly[1]), 16'h0006);
        $display("Test frame position done");
        wr(16'h0400);
        run <= 1'b0;
        for (int v = 0; v < 4; v++) begin
            @(posedge sys_clk);
            {ck2, fp2} <= 2'(v);
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk);
            chk("looped timing", {timing_clk_q, timing_fp_q}, 16'(v));
        end
        wr(16'h0c00);
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("slave ignores loop", {loopback_q, timing_clk_q, timing_fp_q}, 16'h0000);
        $display("Test loopback done");
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(16'h1000);
        clk_en <= 1'b1;
        rd(r);
        chk("frozen write", r, 16'h0c00);
        $display("Test clock enable done");
        end_of_test();
    end
endmodule : test_tsc_timing_control
`default_nettype wire
